// File: rtl/mcp_pkg.sv
// Purpose: shared constants and types for the memory channel port with error correction
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: check-code masks list the data bits that feed each check bit
package mcp_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int CODE_W = 5;
    localparam int CHAN_W = 18;
    localparam int STORE_W = DATA_W + CODE_W;
    localparam int LOW_PAR_BIT = 16;
    localparam int UP_PAR_BIT = 17;

    // least pulse widths round up to whole cycles
    localparam int AR_PULSE_NS = 60;
    localparam int AR_PULSE_CYC = (AR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DR_PULSE_NS = 70;
    localparam int DR_PULSE_CYC = (DR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // write data may trail the request by this much
    localparam int WDATA_LAG_NS = 75;
    localparam int WDATA_LAG_CYC = (WDATA_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [15:0] CHK_MASK0 = 16'h055f;
    localparam logic [15:0] CHK_MASK1 = 16'h5695;
    // bit 6 belongs to check bit 2, else data bits 3 and 6 would share one syndrome
    localparam logic [15:0] CHK_MASK2 = 16'h98e6;
    localparam logic [15:0] CHK_MASK3 = 16'he0f8;
    localparam logic [15:0] CHK_MASK4 = 16'hff00;

    localparam logic [1:0] IRQ_OFF = 2'h0;
    localparam logic [1:0] IRQ_SINGLE = 2'h1;
    localparam logic [1:0] IRQ_MULTI = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETTLE = 3'h1,
        ST_BANK = 3'h2,
        ST_WAIT = 3'h3,
        ST_CHECK = 3'h4
    } mcp_state_t;

endpackage : mcp_pkg

// File: rtl/mcp_check_gen.sv
// Purpose: 5-bit check code over 16 data bits
// Assumes: purely combinational
// Notes: used once for writes and once for read checking
`timescale 1ns/1ps
module mcp_check_gen (
    // data in
    input wire logic [15:0] data,
    // check code out
    output logic [4:0] code
);
    assign code[0] = ^(data & mcp_pkg::CHK_MASK0);
    assign code[1] = ^(data & mcp_pkg::CHK_MASK1);
    assign code[2] = ^(data & mcp_pkg::CHK_MASK2);
    assign code[3] = ^(data & mcp_pkg::CHK_MASK3);
    assign code[4] = ^(data & mcp_pkg::CHK_MASK4);
endmodule : mcp_check_gen

// File: rtl/mcp_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs come from cable pins outside the clock domain
// Notes: a bit changes only once stages two and three agree
`timescale 1ns/1ps
module mcp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pins
    input wire logic [WIDTH-1:0] async_in,
    // filtered level
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    wire [WIDTH-1:0] agree = ~(s2 ^ s3);
    wire [WIDTH-1:0] next_out = (s3 & agree) | (sync_out & ~agree);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("mcp_sync: WIDTH must be at least 1");
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            sync_out <= '0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            sync_out <= next_out;
        end
    end
endmodule : mcp_sync

// File: rtl/mcp_port.sv
// Purpose: memory channel port linking a channel source to bank storage, with error correction
// Assumes: bank storage answers with accept and done pulses; error log takes a syndrome pulse
// Notes: one access in service at a time; one further request may wait
`timescale 1ns/1ps
module mcp_port #(
    parameter int ADDR_W = mcp_pkg::ADDR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // address cable
    input wire logic [ADDR_W-1:0] addr_pin,
    input wire logic req_pin,
    input wire logic write_pin,
    // data cable
    input wire logic [17:0] channel_data_lines_in,
    output logic [17:0] channel_data_lines_out,
    output logic channel_data_lines_oe,
    output logic address_accepted_ack,
    output logic data_done_ack,
    // bank storage
    output logic st_req,
    output logic st_write,
    output logic [ADDR_W-1:0] st_addr,
    output logic [20:0] st_wdata,
    input wire logic st_accept,
    input wire logic st_done,
    input wire logic [20:0] st_rdata,
    // error log
    output logic log_valid,
    output logic [4:0] log_syndrome,
    output logic [ADDR_W-1:0] log_addr,
    // interrupt
    input wire logic [1:0] irq_mode,
    output logic err_irq
);
    generate
        if (ADDR_W != mcp_pkg::ADDR_W) begin : g_bad_addr_w
            $error("mcp_port: address width must be 21");
        end
    endgenerate

    mcp_pkg::mcp_state_t state;
    mcp_pkg::mcp_state_t next_state;

    logic req_s;
    logic wr_s;
    logic req_q;
    logic [ADDR_W-1:0] addr_s;
    logic [17:0] chan_s;
    logic pend;
    logic pend_wr;
    logic [ADDR_W-1:0] pend_addr;
    logic cur_wr;
    logic [3:0] settle_cnt;
    logic [3:0] ar_cnt;
    logic [3:0] dr_cnt;
    logic [20:0] rdata_q;
    logic [4:0] wr_code;
    logic [4:0] rd_code;
    wire [15:0] data_hit;

    // pins pass the three-stage filter before any use
    mcp_sync #(.WIDTH(1)) u_req_sync (
        .clk(clk), .rst_b(rst_b), .async_in(req_pin), .sync_out(req_s));
    mcp_sync #(.WIDTH(1 + ADDR_W + 18)) u_bus_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({write_pin, addr_pin, channel_data_lines_in}),
        .sync_out({wr_s, addr_s, chan_s})
    );

    mcp_check_gen u_wr_gen (.data(chan_s[15:0]), .code(wr_code));
    mcp_check_gen u_rd_gen (.data(rdata_q[15:0]), .code(rd_code));

    wire req_edge = req_s & ~req_q;
    wire [4:0] syndrome = rd_code ^ rdata_q[20:16];
    wire syn_zero = (syndrome == 5'h00);

    // each data bit has a unique syndrome column
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_col
            wire [4:0] col = {mcp_pkg::CHK_MASK4[gi], mcp_pkg::CHK_MASK3[gi],
                mcp_pkg::CHK_MASK2[gi], mcp_pkg::CHK_MASK1[gi], mcp_pkg::CHK_MASK0[gi]};
            assign data_hit[gi] = (syndrome == col);
        end
    endgenerate

    wire data_single = |data_hit;
    wire code_single = $onehot(syndrome);
    wire multi_err = !syn_zero && !data_single && !code_single;
    wire [15:0] corr_data = rdata_q[15:0] ^ data_hit;
    wire low_par = ~^corr_data[7:0];
    wire up_par = ~^corr_data[15:8];
    // a multiple error turns the lower parity wrong so the source's check trips
    wire [17:0] next_chan = {up_par, low_par ^ multi_err, corr_data};
    wire irq_hit = (irq_mode == mcp_pkg::IRQ_SINGLE && (data_single || code_single))
        || (irq_mode == mcp_pkg::IRQ_MULTI && multi_err);

    wire in_check = (state == mcp_pkg::ST_CHECK);
    wire take_pend = (state == mcp_pkg::ST_IDLE) && pend;
    wire bank_acc = (state == mcp_pkg::ST_BANK) && st_accept;
    wire wait_done = (state == mcp_pkg::ST_WAIT) && st_done;
    wire settle_end = (state == mcp_pkg::ST_SETTLE) && (settle_cnt == 4'h0);

    always_comb begin
        next_state = state;
        case (state)
            mcp_pkg::ST_IDLE: begin
                if (pend) next_state = pend_wr ? mcp_pkg::ST_SETTLE : mcp_pkg::ST_BANK;
            end
            mcp_pkg::ST_SETTLE: begin
                if (settle_cnt == 4'h0) next_state = mcp_pkg::ST_BANK;
            end
            mcp_pkg::ST_BANK: begin
                if (st_accept) next_state = mcp_pkg::ST_WAIT;
            end
            mcp_pkg::ST_WAIT: begin
                if (st_done) next_state = cur_wr ? mcp_pkg::ST_IDLE : mcp_pkg::ST_CHECK;
            end
            mcp_pkg::ST_CHECK: begin
                next_state = mcp_pkg::ST_IDLE;
            end
            default: begin
                next_state = mcp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= mcp_pkg::ST_IDLE;
            req_q <= 1'b0;
        end else begin
            state <= next_state;
            req_q <= req_s;
        end
    end

    // a request taken while busy waits here; a new edge wins over the take
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pend <= 1'b0;
            pend_wr <= 1'b0;
            pend_addr <= '0;
        end else if (req_edge) begin
            pend <= 1'b1;
            pend_wr <= wr_s;
            pend_addr <= addr_s;
        end else if (take_pend) begin
            pend <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur_wr <= 1'b0;
            st_addr <= '0;
            settle_cnt <= 4'h0;
        end else if (take_pend) begin
            cur_wr <= pend_wr;
            st_addr <= pend_addr;
            settle_cnt <= 4'(mcp_pkg::WDATA_LAG_CYC - 1);
        end else if (state == mcp_pkg::ST_SETTLE && settle_cnt != 4'h0) begin
            settle_cnt <= settle_cnt - 4'h1;
        end
    end

    // source parity bits are dropped; the code goes with the data
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_wdata <= '0;
        end else if (settle_end) begin
            st_wdata <= {wr_code, chan_s[15:0]};
        end
    end

    assign st_req = (state == mcp_pkg::ST_BANK);
    assign st_write = cur_wr;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_q <= '0;
        end else if (wait_done && !cur_wr) begin
            rdata_q <= st_rdata;
        end
    end

    // acknowledge pulses are stretched to their least widths
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ar_cnt <= 4'h0;
            dr_cnt <= 4'h0;
        end else begin
            if (bank_acc) ar_cnt <= 4'(mcp_pkg::AR_PULSE_CYC);
            else if (ar_cnt != 4'h0) ar_cnt <= ar_cnt - 4'h1;
            if ((wait_done && cur_wr) || in_check) dr_cnt <= 4'(mcp_pkg::DR_PULSE_CYC);
            else if (dr_cnt != 4'h0) dr_cnt <= dr_cnt - 4'h1;
        end
    end

    assign address_accepted_ack = (ar_cnt != 4'h0);
    assign data_done_ack = (dr_cnt != 4'h0);

    // drivers stay on after a read until the source raises write or asks again
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            channel_data_lines_out <= '0;
            channel_data_lines_oe <= 1'b0;
        end else if (in_check) begin
            channel_data_lines_out <= next_chan;
            channel_data_lines_oe <= 1'b1;
        end else if (wr_s || req_edge) begin
            channel_data_lines_oe <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            log_valid <= 1'b0;
            log_syndrome <= 5'h00;
            log_addr <= '0;
            err_irq <= 1'b0;
        end else begin
            log_valid <= in_check && !syn_zero;
            err_irq <= in_check && irq_hit;
            if (in_check && !syn_zero) begin
                log_syndrome <= syndrome;
                log_addr <= st_addr;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_ar_width: assert property ($rose(address_accepted_ack) |-> address_accepted_ack[*6])
        else $error("address ready pulse too short");
    a_ar_cause: assert property ($rose(address_accepted_ack) |-> $past(bank_acc))
        else $error("address ready without bank accept");
    a_dr_width: assert property ($rose(data_done_ack) |-> data_done_ack[*7])
        else $error("data ready pulse too short");
    a_write_code: assert property (st_req && st_write |->
        st_wdata[20:16] == {^(st_wdata[15:0] & mcp_pkg::CHK_MASK4),
        ^(st_wdata[15:0] & mcp_pkg::CHK_MASK3), ^(st_wdata[15:0] & mcp_pkg::CHK_MASK2),
        ^(st_wdata[15:0] & mcp_pkg::CHK_MASK1), ^(st_wdata[15:0] & mcp_pkg::CHK_MASK0)})
        else $error("stored check code wrong");
    a_good_pass: assert property (in_check && syn_zero |=>
        channel_data_lines_out[15:0] == $past(rdata_q[15:0]) && !log_valid)
        else $error("good data altered or logged");
    a_parity_ok: assert property (in_check && !multi_err |=>
        channel_data_lines_out[16] == ~^channel_data_lines_out[7:0] &&
        channel_data_lines_out[17] == ~^channel_data_lines_out[15:8])
        else $error("returned parity wrong");
    a_fix_bit: assert property (in_check && data_single |=>
        $onehot(channel_data_lines_out[15:0] ^ $past(rdata_q[15:0])))
        else $error("single data error not corrected");
    a_log_error: assert property (in_check && !syn_zero |=> log_valid && log_syndrome != 5'h00)
        else $error("nonzero syndrome not logged");
    a_code_err: assert property (in_check && code_single |=>
        channel_data_lines_out[15:0] == $past(rdata_q[15:0]))
        else $error("check bit error altered data");
    a_multi_par: assert property (in_check && multi_err |=>
        channel_data_lines_out[16] == ^channel_data_lines_out[7:0])
        else $error("multiple error parity not forced");
    a_irq_mode: assert property (err_irq |-> irq_mode != mcp_pkg::IRQ_OFF)
        else $error("interrupt while disabled");
    a_drive_read: assert property ($rose(channel_data_lines_oe) |-> !cur_wr && data_done_ack)
        else $error("data lines driven outside a read");
    a_no_stall: assert property (take_pend && !pend_wr |=> st_req)
        else $error("port delayed bank request");
    a_one_access: assert property (req_edge |=> !req_edge)
        else $error("request counted twice");

    c_write: cover property (wait_done && cur_wr);
    c_read_good: cover property (in_check && syn_zero);
    c_corrected: cover property (in_check && data_single);
    c_multi: cover property (in_check && multi_err);

endmodule : mcp_port

// File: tb/mcp_bank_model.sv
// Purpose: bank storage stand-in facing the storage side of the port
// Assumes: one access at a time, st_req held until accept
// Notes: flip corrupts read words; rdata toggles whenever it is not valid
`timescale 1ns/1ps
module mcp_bank_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // storage side of the port
    input wire logic st_req,
    input wire logic st_write,
    input wire logic [20:0] st_addr,
    input wire logic [20:0] st_wdata,
    output logic st_accept,
    output logic st_done,
    output logic [20:0] st_rdata,
    // test controls
    input wire logic [20:0] flip,
    input wire logic slow
);
    logic [20:0] mem [16];
    logic [1:0] ph;
    logic [3:0] cnt;
    logic [3:0] a;
    logic wr;
    int n_acc;

    // stale read data is never left standing, so a late sample shows up
    always @(posedge clk) begin
        st_accept <= 1'b0;
        st_done <= 1'b0;
        st_rdata <= ~st_rdata;
        if (!rst_b) begin
            ph <= 2'h0;
            n_acc <= 0;
            st_rdata <= 21'h0;
        end else if (ph == 2'h0) begin
            ph <= {1'b0, st_req};
            cnt <= slow ? 4'h5 : 4'h0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (ph == 2'h1) begin
            st_accept <= 1'b1;
            n_acc <= n_acc + 1;
            wr <= st_write;
            a <= st_addr[3:0];
            ph <= 2'h2;
            cnt <= slow ? 4'h6 : 4'h1;
        end else begin
            st_done <= 1'b1;
            if (wr) mem[a] <= st_wdata;
            else st_rdata <= mem[a] ^ flip;
            ph <= 2'h0;
        end
    end
endmodule : mcp_bank_model

// File: tb/mcp_port_tb.sv
// Purpose: self-checking bench for the memory channel port
// Assumes: bench acts as channel source, bank model as storage
// Notes: inputs change 1 ns after each rising edge; one access at a time
`timescale 1ns/1ps
module mcp_port_tb;
    logic clk, rst_b, req_pin, write_pin, slow;
    logic [1:0] irq_mode;
    logic [20:0] addr_pin, flip, st_addr, st_wdata, st_rdata, log_addr, la;
    logic [17:0] tb_data, pins, dout, rd;
    logic oe, ar, dr, st_req, st_write, st_accept, st_done, log_valid, err_irq;
    logic got_log, got_irq, oe_dr, oe_any;
    logic [4:0] log_syndrome, syn;
    int ar_w, dr_w, lat, n_mismatch, n_compared;

    // the port's own drivers win the shared lines while enabled
    assign pins = oe ? dout : tb_data;

    mcp_port u_dut (
        .clk(clk), .rst_b(rst_b), .addr_pin(addr_pin), .req_pin(req_pin),
        .write_pin(write_pin), .channel_data_lines_in(pins), .channel_data_lines_out(dout),
        .channel_data_lines_oe(oe), .address_accepted_ack(ar), .data_done_ack(dr),
        .st_req(st_req), .st_write(st_write), .st_addr(st_addr), .st_wdata(st_wdata),
        .st_accept(st_accept), .st_done(st_done), .st_rdata(st_rdata),
        .log_valid(log_valid), .log_syndrome(log_syndrome), .log_addr(log_addr),
        .irq_mode(irq_mode), .err_irq(err_irq)
    );

    mcp_bank_model u_bank (
        .clk(clk), .rst_b(rst_b), .st_req(st_req), .st_write(st_write), .st_addr(st_addr),
        .st_wdata(st_wdata), .st_accept(st_accept), .st_done(st_done), .st_rdata(st_rdata),
        .flip(flip), .slow(slow)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [4:0] ecc(input logic [15:0] d);
        return {^(d & 16'hff00), ^(d & 16'he0f8), ^(d & 16'h98e6), ^(d & 16'h5695),
                ^(d & 16'h055f)};
    endfunction : ecc

    function automatic logic [17:0] exp_out(input logic [15:0] d, input logic bad);
        return {~^d[15:8], bad ^ (~^d[7:0]), d};
    endfunction : exp_out

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic cmp_v(input logic [20:0] got, input logic [20:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: word %h, want %h", $time, got, exp);
        end
    endtask : cmp_v

    task automatic cmp_b(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask : cmp_b

    task automatic cmp_n(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("unexpected at %0t: count %0d, want %0d..%0d", $time, got, lo, hi);
        end
    endtask : cmp_n

    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    // one access as channel source; returns when the data-ready pulse has ended
    task automatic access(input logic wr, input logic [20:0] a, input logic [17:0] d);
        bit fin;
        fin = 1'b0;
        ar_w = 0;
        dr_w = 0;
        got_log = 1'b0;
        got_irq = 1'b0;
        oe_any = 1'b0;
        addr_pin = a;
        write_pin = wr;
        tb_data = wr ? d : ~tb_data;
        req_pin = 1'b1;
        // the source gives up only after more than 10 us without an answer
        for (int i = 1; i < 1100 && !fin; i++) begin
            step();
            if (i == 6) req_pin = 1'b0;
            ar_w += int'(ar);
            oe_any |= oe;
            got_irq |= err_irq;
            got_log |= log_valid;
            if (log_valid) syn = log_syndrome;
            if (log_valid) la = log_addr;
            if (dr && dr_w == 0) lat = i;
            if (dr && dr_w == 0) rd = dout;
            if (dr && dr_w == 0) oe_dr = oe;
            if (dr) dr_w++;
            else if (dr_w != 0) fin = 1'b1;
        end
        if (!fin) begin
            n_mismatch++;
            $display("unexpected at %0t: data ready never ended", $time);
            results();
        end
    endtask : access

    task automatic wr_chk(input logic [20:0] a, input logic [17:0] d, input int lim);
        access(1'b1, a, d);
        cmp_v(u_bank.mem[a[3:0]], {ecc(d[15:0]), d[15:0]});
        cmp_b(oe_any, 1'b0);
        cmp_n(ar_w, 6, 6);
        cmp_n(dr_w, 7, 7);
        cmp_n(lat * 10, 1, lim);
    endtask : wr_chk

    task automatic rd_chk(input logic [20:0] a, input logic [17:0] e, input logic [4:0] s,
                          input logic irq, input int lim);
        access(1'b0, a, 18'h0);
        cmp_v(21'(rd), 21'(e));
        cmp_b(got_log, s != 5'h0);
        if (s != 5'h0) cmp_v(21'(syn), 21'(s));
        if (s != 5'h0) cmp_v(la, a);
        cmp_b(got_irq, irq);
        cmp_b(oe_dr, 1'b1);
        cmp_n(ar_w, 6, 6);
        cmp_n(dr_w, 7, 7);
        cmp_n(lat * 10, 1, lim);
        write_pin = 1'b1;
        for (int k = 0; k < 10 && oe !== 1'b0; k++) step();
        cmp_b(oe, 1'b0);
    endtask : rd_chk

    task automatic t_basic;
        int n0;
        n0 = u_bank.n_acc;
        wr_chk(21'h1ffff3, {2'b00, 16'ha5c3}, 200);
        rd_chk(21'h1ffff3, exp_out(16'ha5c3, 1'b0), 5'h0, 1'b0, 450);
        cmp_n(u_bank.n_acc - n0, 2, 2);
    endtask : t_basic

    task automatic t_single;
        irq_mode = 2'h1;
        wr_chk(21'h100005, {2'b01, 16'h3c96}, 200);
        for (int i = 0; i < 16; i++) begin
            flip = 21'h1 << i;
            rd_chk(21'h100005, exp_out(16'h3c96, 1'b0), ecc(16'h1 << i), 1'b1, 500);
        end
    endtask : t_single

    task automatic t_code;
        irq_mode = 2'h2;
        for (int j = 0; j < 5; j++) begin
            flip = 21'h1 << (16 + j);
            rd_chk(21'h100005, exp_out(16'h3c96, 1'b0), 5'h1 << j, 1'b0, 500);
        end
    endtask : t_code

    task automatic t_multi;
        flip = 21'h3;
        for (int m = 0; m < 4; m++) begin
            irq_mode = 2'(m);
            rd_chk(21'h100005, exp_out(16'h3c95, 1'b1), ecc(16'h3), m == 2, 500);
        end
        flip = 21'h0;
    endtask : t_multi

    task automatic t_slow;
        slow = 1'b1;
        wr_chk(21'h00000a, {2'b11, 16'h0000}, 9999);
        rd_chk(21'h00000a, exp_out(16'h0000, 1'b0), 5'h0, 1'b0, 9999);
        slow = 1'b0;
    endtask : t_slow

    initial begin
        rst_b = 1'b0;
        req_pin = 1'b0;
        write_pin = 1'b1;
        addr_pin = 21'h0;
        tb_data = 18'h0;
        flip = 21'h0;
        slow = 1'b0;
        irq_mode = 2'h0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (6) step();
        cmp_v(21'({ar, dr, oe, log_valid, err_irq}), 21'h0);
        t_basic();
        t_single();
        t_code();
        t_multi();
        t_slow();
        results();
    end
endmodule : mcp_port_tb
